// ==== logic/chk_read_pkg.sv ====
package chk_read_pkg;

  // --------------------------------------------------------------
  // clock and delay timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned VBC_DELAY_MS     = 75;
  localparam int unsigned RUNAWAY_DELAY_MS = 100;
  localparam int unsigned SPROCKET_DELAY_US = 1500;
  localparam int unsigned VBC_CYCLES =
    (CLK_HZ / 1000) * VBC_DELAY_MS;
  localparam int unsigned RUNAWAY_CYCLES =
    (CLK_HZ / 1000) * RUNAWAY_DELAY_MS;
  localparam int unsigned SPROCKET_CYCLES =
    (CLK_HZ / 1_000_000) * SPROCKET_DELAY_US;

  // --------------------------------------------------------------
  // character counter
  // --------------------------------------------------------------
  localparam int unsigned CNT_W         = 7;
  localparam logic [6:0]  CNT_RESET     = 7'h00;
  localparam logic [6:0]  CNT_LAST      = 7'h77;  // 119
  localparam logic [6:0]  CNT_WIN_START = 7'h0b;  // 11
  localparam logic [6:0]  CNT_WIN_END   = 7'h6b;  // 107

  // --------------------------------------------------------------
  // synchronizers and register map
  // --------------------------------------------------------------
  localparam int unsigned NUM_SYNC     = 4;
  localparam logic [7:0]  CONNECT_CODE = 8'h41;   // instruction 65
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [3:0]  REG_COUNT    = 4'h8;
  localparam logic [3:0]  REG_CMD      = 4'hc;
  // control register bit positions
  localparam int unsigned CTRL_CONT    = 0;
  localparam int unsigned CTRL_FMT_OLD = 1;
  // command field: [7:0] code, [9:8] synchronizer select
  localparam int unsigned CMD_SEL_LSB  = 8;
  localparam int unsigned CMD_CLR_TW   = 16;

endpackage

// ==== logic/delay_timer.sv ====
`timescale 1ns/100ps
// retriggerable one-shot down-counter on the system clock
module delay_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      expire
);

  localparam int unsigned W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         expire;
  } state_t;

  state_t cur_q;
  state_t cur_d;

  // load on start, pulse expire when the count runs out
  always_comb begin
    cur_d        = cur_q;
    cur_d.expire = 1'b0;
    if (start) begin
      cur_d.cnt  = W'(CYCLES - 1);
      cur_d.busy = 1'b1;
    end else if (cur_q.busy) begin
      if (cur_q.cnt == '0) begin
        cur_d.busy   = 1'b0;
        cur_d.expire = 1'b1;
      end else begin
        cur_d.cnt = cur_q.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= cur_d;
    end
  end

  assign busy   = cur_q.busy;
  assign expire = cur_q.expire;

endmodule

// ==== logic/check_read_count_and_error_detect.sv ====
`timescale 1ns/100ps
// Function
// - last sprocket under bad-spot gating sets possible flag, starts timer
// - after 75 ms, possible flag still set confirms very bad count
// - bad spot or inter-block space during delay clears possible flag
// - blockette tape: end-count on read cycle clears possible flag
// - photocell pulse, or bad-spot flag on forward read, clears flag
// - last sprocket with confirmed flag raises error, starts read ending
// - runaway flag set on confirmation, cleared by any read cycle with character data after the confirming cycle
// - runaway flag still set after 100 ms gives runaway error
// - attached synchronizer read path goes to checker; writes unaffected
// - check-read data only parity-checked, never stored to buffers
// - four connect flags; connect code 65 sets one, starts reading, unless old format, continue, ten-word or a connect flag is set
// - release pulse clears connect flag unless continue flag set
// - seven-stage binary counter counts characters of ten-word group
// - counter cleared at check-read start and on hash pulse
// - step per read cycle; stage toggles when all lower stages one
// - step at 119 resets all stages to zero
// - wrap step sets group-complete flag, equivalent to count zero
// - counts 11 and 107 gated with step mark alert window
// - last sprocket made 1.5 ms after character before a break
// - first-char step with group-complete set clears it and continue, sets ten-word
module check_read_count_and_error_detect #(
  parameter int unsigned VBC_CYC     = chk_read_pkg::VBC_CYCLES,
  parameter int unsigned RUNAWAY_CYC = chk_read_pkg::RUNAWAY_CYCLES,
  parameter int unsigned SPR_CYC     = chk_read_pkg::SPROCKET_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // synchronizer read circuits, one lane each
  input  wire logic [3:0]  tapeReadCycle,
  input  wire logic [3:0]  hashPulse,
  input  wire logic [3:0]  readEndReleasePulse,
  input  wire logic [3:0]  readCharData,
  // attached read path events
  input  wire logic        badSpotGating,
  input  wire logic        blocketteEndCount,
  input  wire logic        photocellBadSpotPulse,
  input  wire logic        badSpotFlagClear,
  input  wire logic        readForward,
  input  wire logic        blocketteFormat,
  // outputs to synchronizers and checker
  output logic      [3:0]  connectFlag,
  output logic      [3:0]  startRead,
  output logic      [3:0]  readPathToChecker,
  output logic             translateCheckEn,
  output logic             bufferWriteEn,
  output logic             lastSprocketEvent,
  output logic             alertWindowStart,
  output logic             alertWindowEnd,
  output logic             groupCompleteFlag,
  output logic             tenWordFlag,
  output logic             continueFlag,
  output logic             veryBadCountErr,
  output logic             tapeRunawayErr,
  output logic             readEndStart
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  connect;
    logic [3:0]  startRd;
    logic        xlate;
    logic [6:0]  count;
    logic        groupDone;
    logic        tenWord;
    logic        cont;
    logic        possVbc;
    logic        vbc;
    logic        runaway;
    logic        vbcErr;
    logic        runErr;
    logic        readEnd;
    logic        errSticky;
    logic        fmtOld;
    logic        winStart;
    logic        winEnd;
    logic        lastSpr;
    logic [16:0] gapCnt;
    logic        gapArmed;
    logic        ack;
    logic [31:0] rdat;
  } state_t;

  state_t cur_q;
  state_t cur_d;

  // ------------------------------------------------------------
  // delay timers
  // ------------------------------------------------------------
  logic vbcStart;
  logic vbcExpire;
  logic runStart;
  logic runExpire;

  delay_timer #(.CYCLES(VBC_CYC)) vbcTimer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (vbcStart),
    .busy    (),
    .expire  (vbcExpire)
  );

  delay_timer #(.CYCLES(RUNAWAY_CYC)) runTimer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (runStart),
    .busy    (),
    .expire  (runExpire)
  );

  // ------------------------------------------------------------
  // attached lane selection
  // ------------------------------------------------------------
  logic attached;
  logic stepEv;
  logic hashEv;
  logic releaseEv;
  logic anyChar;

  // only the attached lane reaches the checker
  assign attached  = |cur_q.connect;
  assign stepEv    = |(tapeReadCycle & cur_q.connect);
  assign hashEv    = |(hashPulse & cur_q.connect);
  assign releaseEv = |(readEndReleasePulse & cur_q.connect);
  assign anyChar   = stepEv & (|(readCharData & cur_q.connect));

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic busReq;
  logic wrCtrl;
  logic wrCmd;
  logic connectCmd;
  logic [1:0] selLane;

  // single-cycle ack, dropped the cycle after it was given
  assign busReq = wb_cyc_i & wb_stb_i & ~cur_q.ack;
  assign wrCtrl = busReq & wb_we_i & wb_sel_i[0]
                  & (wb_adr_i == chk_read_pkg::REG_CTRL);
  assign wrCmd  = busReq & wb_we_i & wb_sel_i[0]
                  & (wb_adr_i == chk_read_pkg::REG_CMD);
  assign selLane = wb_dat_i[chk_read_pkg::CMD_SEL_LSB +: 2];
  assign connectCmd = wrCmd & wb_sel_i[1]
                    & (wb_dat_i[7:0] == chk_read_pkg::CONNECT_CODE);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [6:0] stepped;
  logic       clrPoss;
  logic       carry;

  always_comb begin
    cur_d          = cur_q;
    cur_d.startRd  = 4'h0;
    cur_d.winStart = 1'b0;
    cur_d.winEnd   = 1'b0;
    cur_d.vbcErr   = 1'b0;
    cur_d.runErr   = 1'b0;
    cur_d.readEnd  = 1'b0;
    cur_d.lastSpr  = 1'b0;
    cur_d.ack      = busReq;
    vbcStart       = 1'b0;
    runStart       = 1'b0;
    stepped        = cur_q.count;

    // last sprocket 1.5 ms after final character
    if (stepEv) begin
      cur_d.gapCnt   = 17'(SPR_CYC - 1);
      cur_d.gapArmed = attached;
    end else if (cur_q.gapArmed) begin
      if (cur_q.gapCnt == '0) begin
        cur_d.gapArmed = 1'b0;
        cur_d.lastSpr  = 1'b1;
      end else begin
        cur_d.gapCnt = cur_q.gapCnt - 17'(1);
      end
    end

    // ripple-style toggle: each stage flips when lower ones all one
    carry = 1'b1;
    for (int i = 0; i < chk_read_pkg::CNT_W; i++) begin
      stepped[i] = cur_q.count[i] ^ carry;
      carry      = carry & cur_q.count[i];
    end

    // software clear first, so a new group in the same cycle wins
    if (wrCmd & wb_dat_i[chk_read_pkg::CMD_CLR_TW]) begin
      cur_d.tenWord = 1'b0;
    end

    if (hashEv) begin
      cur_d.count = chk_read_pkg::CNT_RESET;
    end else if (stepEv) begin
      if (cur_q.count == chk_read_pkg::CNT_LAST) begin
        cur_d.count = chk_read_pkg::CNT_RESET;
        cur_d.groupDone = 1'b1;
      end else begin
        cur_d.count = stepped;
        if (cur_q.groupDone) begin
          cur_d.groupDone = 1'b0;
          cur_d.cont      = 1'b0;
          cur_d.tenWord   = 1'b1;
        end
      end
      // alert window decodes gated with step
      cur_d.winStart = (cur_q.count == chk_read_pkg::CNT_WIN_START);
      cur_d.winEnd   = (cur_q.count == chk_read_pkg::CNT_WIN_END);
    end

    // clear sources for the possible flag
    clrPoss = 1'b0;
    if (blocketteFormat & stepEv & blocketteEndCount) begin
      clrPoss = 1'b1;
    end
    // photocell pulse, or bad-spot flag during forward read
    if (photocellBadSpotPulse | (readForward & badSpotFlagClear)) begin
      clrPoss = 1'b1;
    end
    if (clrPoss) begin
      cur_d.possVbc = 1'b0;
    end

    if (cur_q.lastSpr) begin
      // error only on last sprocket with confirmed flag
      if (cur_q.vbc) begin
        cur_d.vbcErr    = 1'b1;
        cur_d.readEnd   = 1'b1;
        cur_d.vbc       = 1'b0;
        cur_d.errSticky = 1'b1;
      // possible very bad count, start timer
      end else if (badSpotGating) begin
        cur_d.possVbc = 1'b1;
        vbcStart      = 1'b1;
      end
    end

    // test flag when the 75 ms delay ends
    if (vbcExpire & cur_q.possVbc & ~clrPoss) begin
      cur_d.possVbc = 1'b0;
      cur_d.vbc     = 1'b1;
      cur_d.runaway = 1'b1;
      runStart      = 1'b1;
    end

    // any data read after the confirming cycle clears runaway flag
    if (anyChar & ~runStart) begin
      cur_d.runaway = 1'b0;
    end

    if (runExpire & cur_q.runaway & ~anyChar) begin
      cur_d.runErr    = 1'b1;
      cur_d.readEnd   = 1'b1;
      cur_d.runaway   = 1'b0;
      cur_d.vbc       = 1'b0;
      cur_d.errSticky = 1'b1;
    end

    if (releaseEv & ~cur_q.cont) begin
      cur_d.connect = 4'h0;
    end

    // control register writes
    if (wrCtrl) begin
      cur_d.cont   = wb_dat_i[chk_read_pkg::CTRL_CONT];
      cur_d.fmtOld = wb_dat_i[chk_read_pkg::CTRL_FMT_OLD];
    end

    // connect selects one lane and starts reading
    if (connectCmd) begin
      if (attached | cur_q.cont | cur_q.tenWord) begin
        cur_d.errSticky = 1'b1;
      end else if (~cur_q.fmtOld) begin
        cur_d.connect  = 4'(1) << selLane;
        cur_d.startRd  = 4'(1) << selLane;
        // start of check read clears counter
        cur_d.count     = chk_read_pkg::CNT_RESET;
        cur_d.groupDone = 1'b1;
        cur_d.errSticky = 1'b0;
      end
    end

    // translator check follows the final connect flags
    cur_d.xlate = |cur_d.connect;

    // read data mux, unmapped reads as zero
    cur_d.rdat = 32'h0000_0000;
    unique case (wb_adr_i)
      chk_read_pkg::REG_CTRL:
        cur_d.rdat = {30'h0, cur_q.fmtOld, cur_q.cont};
      chk_read_pkg::REG_STATUS:
        cur_d.rdat = {22'h0, cur_q.errSticky, cur_q.runaway,
                      cur_q.vbc, cur_q.possVbc, cur_q.tenWord,
                      cur_q.groupDone, cur_q.connect};
      chk_read_pkg::REG_COUNT:
        cur_d.rdat = {25'h0, cur_q.count};
      default:
        cur_d.rdat = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= cur_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flip-flops except the tied-low buffer write enable
  // ------------------------------------------------------------
  assign wb_dat_o          = cur_q.rdat;
  assign wb_ack_o          = cur_q.ack;
  assign connectFlag       = cur_q.connect;
  assign startRead         = cur_q.startRd;
  // read path steering follows connect flags
  assign readPathToChecker = cur_q.connect;
  // parity check only, buffers never written
  assign translateCheckEn  = cur_q.xlate;
  assign bufferWriteEn     = 1'b0;
  assign lastSprocketEvent = cur_q.lastSpr;
  assign alertWindowStart  = cur_q.winStart;
  assign alertWindowEnd    = cur_q.winEnd;
  assign groupCompleteFlag = cur_q.groupDone;
  assign tenWordFlag       = cur_q.tenWord;
  assign continueFlag      = cur_q.cont;
  assign veryBadCountErr   = cur_q.vbcErr;
  assign tapeRunawayErr    = cur_q.runErr;
  assign readEndStart      = cur_q.readEnd;

endmodule

// ==== verif/chk_read_monitor.sv ====
`timescale 1ns/100ps
module chk_read_monitor (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // lanes
  input wire logic [3:0] tapeReadCycle,
  input wire logic [3:0] hashPulse,
  input wire logic [3:0] connectFlag,
  input wire logic [3:0] startRead,
  input wire logic [3:0] readPathToChecker,
  // status and events
  input wire logic       translateCheckEn,
  input wire logic       bufferWriteEn,
  input wire logic       alertWindowStart,
  input wire logic       alertWindowEnd,
  input wire logic       lastSprocketEvent,
  input wire logic       groupCompleteFlag,
  input wire logic       tenWordFlag,
  input wire logic       continueFlag,
  input wire logic       veryBadCountErr,
  input wire logic       tapeRunawayErr,
  input wire logic       readEndStart
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       step;
  logic       hash;
  logic [3:0] conn_q;
  logic [6:0] cnt_q;
  // shadow group count; hash wins over a step
  assign step = |(tapeReadCycle & connectFlag) && !hash;
  assign hash = |(hashPulse & connectFlag);
  always_ff @(posedge clk_sys) begin
    conn_q <= rst ? 4'h0 : connectFlag;
    if (rst || (connectFlag & ~conn_q) != 4'h0 || hash)
      cnt_q <= 7'h00;
    else if (step)
      cnt_q <= (cnt_q == 7'h77) ? 7'h00 : cnt_q + 7'h01;
  end
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack one cycle after request");
  AST_NO_BUFFER: assert property (bufferWriteEn == 1'b0)
    else $error("buffer write during check read");
  AST_PATH: assert property (readPathToChecker == connectFlag &&
    translateCheckEn == (|connectFlag)) else $error("read path wrong");
  AST_START: assert property (startRead != 4'h0 |->
    startRead == (connectFlag & ~conn_q) ##1 startRead == 4'h0)
    else $error("start pulse not tied to new connect");
  AST_VBC_END: assert property (veryBadCountErr |-> readEndStart
    ##1 !veryBadCountErr) else $error("very bad count without ending");
  AST_RUN_END: assert property (tapeRunawayErr |-> readEndStart)
    else $error("runaway without ending");
  AST_WIN_START: assert property (step && cnt_q == 7'h0b
    |=> alertWindowStart) else $error("window start missing");
  AST_WRAP: assert property (step && cnt_q == 7'h77
    |=> groupCompleteFlag) else $error("group complete missing");
  AST_NEW_GROUP: assert property (step && groupCompleteFlag |=>
    tenWordFlag && !continueFlag && !groupCompleteFlag)
    else $error("new group flags wrong");
  AST_WIN_END: assert property (step && cnt_q == 7'h6b
    |=> alertWindowEnd) else $error("window end missing");
  AST_SPR_QUIET: assert property (step
    |=> !lastSprocketEvent) else $error("last sprocket right after step");
endmodule
bind check_read_count_and_error_detect chk_read_monitor
  chk_read_monitor_i (.*);

// ==== verif/sync_read_model.sv ====
`timescale 1ns/100ps
module sync_read_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // burst request
  input  wire logic       go,
  input  wire logic [1:0] lane,
  input  wire logic [7:0] nChars,
  input  wire logic [2:0] gap,
  // read circuit side
  output logic      [3:0] tapeReadCycle,
  output logic            readCharData,
  output logic            busy
);
  logic [7:0] left_q;
  logic [2:0] wait_q;
  logic       flip_q;
  // one character per slot; a large gap models a slow tape
  always_ff @(posedge clk_sys) begin
    flip_q        <= rst ? 1'b0 : ~flip_q;
    tapeReadCycle <= 4'h0;
    if (rst) begin
      left_q <= 8'h00;
      wait_q <= 3'h0;
    end else if (go) begin
      left_q <= nChars;
      wait_q <= gap;
    end else if (left_q != 8'h00) begin
      if (wait_q == 3'h0) begin
        tapeReadCycle[lane] <= 1'b1;
        left_q              <= left_q - 8'h01;
        wait_q              <= gap;
      end else
        wait_q <= wait_q - 3'h1;
    end
  end
  // data line wanders between characters, never holds a stale level
  assign readCharData = (|tapeReadCycle) | flip_q;
  assign busy         = left_q != 8'h00;
endmodule

// ==== verif/tb_check_read_count_and_error_detect.sv ====
`timescale 1ns/100ps
module tb_check_read_count_and_error_detect;
  localparam int unsigned VBC = 20;
  localparam int unsigned RUN = 30;
  localparam int unsigned SPR = 5;
  logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0]  tapeReadCycle, hashPulse, readEndReleasePulse, connectFlag;
  logic        readCharData, badSpotGating, mGo, mBusy, vbcErr, runErr;
  logic [2:0]  clr, mGap;
  logic [1:0]  ln, mLane;
  logic [7:0]  mChars;
  int          miscompares = 0, n_checks = 0, seed = 38435, total = 0;
  int          nVbc = 0, nRun = 0;
  check_read_count_and_error_detect #(.VBC_CYC(VBC), .RUNAWAY_CYC(RUN),
    .SPR_CYC(SPR)) check_read_count_and_error_detect_i (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tapeReadCycle(tapeReadCycle), .hashPulse(hashPulse),
    .readEndReleasePulse(readEndReleasePulse),
    .readCharData({4{readCharData}}), .badSpotGating(badSpotGating),
    .blocketteEndCount(clr[2]), .photocellBadSpotPulse(clr[0]),
    .badSpotFlagClear(clr[1]), .readForward(clr[1]),
    .blocketteFormat(clr[2]), .connectFlag(connectFlag), .startRead(),
    .readPathToChecker(), .translateCheckEn(), .bufferWriteEn(),
    .lastSprocketEvent(), .alertWindowStart(), .alertWindowEnd(),
    .groupCompleteFlag(), .tenWordFlag(), .continueFlag(),
    .veryBadCountErr(vbcErr), .tapeRunawayErr(runErr), .readEndStart());
  sync_read_model sync_read_model_i (.clk_sys(clk_sys), .rst(rst),
    .go(mGo), .lane(mLane), .nChars(mChars), .gap(mGap),
    .tapeReadCycle(tapeReadCycle), .readCharData(readCharData),
    .busy(mBusy));
  // error pulse tallies
  always @(posedge clk_sys) begin
    nVbc <= nVbc + int'(vbcErr === 1'b1);
    nRun <= nRun + int'(runErr === 1'b1);
  end
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; released only at the edge that sees ack
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i >= 20) begin
      miscompares++;
      results();
    end
  endtask
  task automatic burst(input logic [1:0] l, input int n);
    int i;
    @(posedge clk_sys);
    mLane  <= l;
    mChars <= n[7:0];
    mGap   <= 3'($random(seed) & 3);
    mGo    <= 1'b1;
    if (l == ln) total += n;
    @(posedge clk_sys);
    mGo <= 1'b0;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (mBusy !== 1'b0 && i < 2000);
    if (i >= 2000) begin
      miscompares++;
      results();
    end
  endtask
  task automatic lanePulse(input logic rel);
    @(posedge clk_sys);
    if (rel) readEndReleasePulse <= 4'h1 << ln;
    else hashPulse <= 4'h1 << ln;
    @(posedge clk_sys);
    readEndReleasePulse <= 4'h0;
    hashPulse <= 4'h0;
    @(posedge clk_sys);
    if (!rel) total = 0;
  endtask
  function automatic logic [31:0] cmd(input logic [1:0] l);
    return {22'h0, l, chk_read_pkg::CONNECT_CODE};
  endfunction
  function automatic logic [31:0] expCount(input int t);
    return 32'(t % 120);
  endfunction
  function automatic logic [31:0] lanes(input logic [3:0] v);
    return {28'h0, v};
  endfunction
  initial begin
    int k;
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, mGo, badSpotGating} = 5'h00;
    {wb_adr_i, wb_sel_i, hashPulse, readEndReleasePulse} = 16'h0000;
    {wb_dat_i, clr, mGap, mLane, mChars} = 48'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    wb(chk_read_pkg::REG_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    wb(4'h2, 1'b0, 32'h0);
    chk(rd, 32'h0);
    ln = 2'($random(seed));
    wb(chk_read_pkg::REG_CTRL, 1'b1, 32'h2);
    wb(chk_read_pkg::REG_CMD, 1'b1, cmd(ln));
    chk(lanes(connectFlag), 32'h0);
    // release honours continue, then a clean connect
    for (k = 0; k < 3; k++) begin
      wb(chk_read_pkg::REG_CTRL, 1'b1, 32'h0);
      if (k != 1) wb(chk_read_pkg::REG_CMD, 1'b1, cmd(ln));
      chk(lanes(connectFlag), lanes(4'h1 << ln));
      wb(chk_read_pkg::REG_CTRL, 1'b1, 32'(k == 0));
      if (k < 2) lanePulse(1'b1);
      chk(lanes(connectFlag), k == 1 ? 32'h0 : lanes(4'h1 << ln));
    end
    total = 0;
    wb(chk_read_pkg::REG_STATUS, 1'b0, 32'h0);
    chk({31'h0, rd[4]}, 32'h1);
    burst(ln + 2'h1, 9);
    wb(chk_read_pkg::REG_COUNT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // continue set, so the first step of the group must clear it
    wb(chk_read_pkg::REG_CTRL, 1'b1, 32'h1);
    burst(ln, 1);
    wb(chk_read_pkg::REG_CTRL, 1'b0, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    wb(chk_read_pkg::REG_STATUS, 1'b0, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h2);
    wb(chk_read_pkg::REG_CMD, 1'b1, 32'h10000);
    burst(ln, 1 + ($random(seed) & 63));
    wb(chk_read_pkg::REG_COUNT, 1'b0, 32'h0);
    chk(rd, expCount(total));
    burst(ln, 120 - total % 120);
    wb(chk_read_pkg::REG_COUNT, 1'b0, 32'h0);
    chk(rd, expCount(total));
    wb(chk_read_pkg::REG_STATUS, 1'b0, 32'h0);
    chk({31'h0, rd[4]}, 32'h1);
    burst(ln, 5);
    lanePulse(1'b0);
    wb(chk_read_pkg::REG_COUNT, 1'b0, 32'h0);
    chk(rd, expCount(total));
    // three clears of a possible very bad count, then confirmation
    for (k = 0; k < 4; k++) begin
      badSpotGating <= 1'b1;
      burst(ln, 1 + ($random(seed) & 15));
      repeat (SPR + 4) @(posedge clk_sys);
      badSpotGating <= 1'b0;
      wb(chk_read_pkg::REG_STATUS, 1'b0, 32'h0);
      chk({31'h0, rd[6]}, 32'h1);
      if (k < 3) begin
        clr <= 3'(1 << k);
        if (k == 2) burst(ln, 1);
        @(posedge clk_sys);
        clr <= 3'h0;
      end
      repeat (VBC + 10) @(posedge clk_sys);
      wb(chk_read_pkg::REG_STATUS, 1'b0, 32'h0);
      chk({30'h0, rd[8:7]}, k < 3 ? 32'h0 : 32'h3);
    end
    burst(ln, 1);
    wb(chk_read_pkg::REG_STATUS, 1'b0, 32'h0);
    chk({31'h0, rd[8]}, 32'h0);
    repeat (SPR + 6) @(posedge clk_sys);
    chk(32'(nVbc), 32'h1);
    // break with no further data runs into the runaway limit
    badSpotGating <= 1'b1;
    burst(ln, 3);
    repeat (SPR + 4) @(posedge clk_sys);
    badSpotGating <= 1'b0;
    repeat (VBC + RUN + 20) @(posedge clk_sys);
    chk(32'(nRun), 32'h1);
    chk(32'(nVbc), 32'h1);
    results();
  end
endmodule
